/* testbench/cmsg_port_asserts.sv */
// cmsg_port_asserts.sv: timing checks on the message port
// assumes: bound into cmsg_port, one clock
`timescale 1ns/1ns
module cmsg_port_asserts (
  // clock, reset, enable
  input wire logic                   clk_sys,
  input wire logic                   rst,
  input wire logic                   rx_notice_port_enable_attr,
  // receive
  input wire logic                   msg_rx_strobe,
  input wire logic [4:0]             msg_rx_type,
  input wire logic [7:0]             msg_rx_data,
  // transmit
  input wire logic [2:0]             msg_tx_type,
  input wire logic [31:0]            msg_tx_data,
  input wire logic                   msg_tx_done,
  input wire cmsg_pkg::cmsg_tx_out_t tx_msg_q,
  input wire logic                   tx_msg_start,
  input wire logic                   tx_msg_reserved
);
  logic [31:0] keep_w;
  // bits each defined transmit type (0 to 3) carries; the rest must come out zero
  assign keep_w = msg_tx_type == 3'h0 ? 32'h9FFF_9FFF : msg_tx_type == 3'h1 ? 32'h0000_000F
                : msg_tx_type == 3'h2 ? 32'h0000_03FF : 32'h0000_03F3;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_rx_gap: assert property ($fell(msg_rx_strobe) |=> !msg_rx_strobe)
    else $error("rx gap short");
  a_rx_idle: assert property (!msg_rx_strobe |-> msg_rx_data == 8'h00)
    else $error("rx data off strobe");
  a_rx_type: assert property (msg_rx_strobe && $past(msg_rx_strobe) |-> $stable(msg_rx_type))
    else $error("rx type moved");
  a_rx_gate: assert property ($rose(msg_rx_strobe) |-> $past(rx_notice_port_enable_attr, 3))
    else $error("rx while off");
  a_tx_lat: assert property (tx_msg_start |=> !msg_tx_done [*3] ##1 msg_tx_done)
    else $error("done latency");
  a_tx_once: assert property (msg_tx_done |=> !msg_tx_done)
    else $error("done too long");
  a_tx_nodup: assert property (msg_tx_done |-> !tx_msg_start)
    else $error("request taken twice");
  a_tx_kind: assert property (tx_msg_start |=>
    tx_msg_q.kind == $past(msg_tx_type) && tx_msg_reserved == ($past(msg_tx_type) > 3'h3))
    else $error("tx kind");
  a_tx_fields: assert property (tx_msg_start && !msg_tx_type[2] |=>
    tx_msg_q.fields == ($past(msg_tx_data) & $past(keep_w)))
    else $error("tx fields");
endmodule // cmsg_port_asserts
bind cmsg_port cmsg_port_asserts chk_u (.clk_sys, .rst, .rx_notice_port_enable_attr,
  .msg_rx_strobe, .msg_rx_type, .msg_rx_data, .msg_tx_type, .msg_tx_data, .msg_tx_done,
  .tx_msg_q, .tx_msg_start, .tx_msg_reserved);

/* testbench/cmsg_port_test.sv */
// cmsg_port_test.sv: self-checking bench for the message port
// assumes: user model on the user side, bench drives the link side
`timescale 1ns/1ns
module cmsg_port_test;
  logic                   clk_sys = 1'b0;
  logic                   rst = 1'b1;
  logic                   rx_notice_port_enable_attr = 1'b1;
  logic                   link_msg_valid = 1'b0;
  cmsg_pkg::cmsg_rx_msg_t link_msg = '0;
  logic                   link_msg_ready, msg_rx_strobe, msg_tx_req, msg_tx_done;
  logic                   tx_msg_start, tx_msg_reserved;
  logic [4:0]             msg_rx_type;
  logic [7:0]             msg_rx_data;
  logic [2:0]             msg_tx_type;
  logic [31:0]            msg_tx_data;
  cmsg_pkg::cmsg_tx_out_t tx_msg_q;
  int                     failures = 0;
  int                     check_count = 0;
  cmsg_port dut_u (.clk_sys, .rst, .rx_notice_port_enable_attr, .link_msg_valid, .link_msg,
    .link_msg_ready, .msg_rx_strobe, .msg_rx_type, .msg_rx_data, .msg_tx_req, .msg_tx_type,
    .msg_tx_data, .msg_tx_done, .tx_msg_q, .tx_msg_start, .tx_msg_reserved);
  cmsg_user_model um_u (.clk_sys, .msg_rx_strobe, .msg_rx_type, .msg_rx_data, .msg_tx_done,
    .msg_tx_req, .msg_tx_type, .msg_tx_data);
  always #50 clk_sys = ~clk_sys;
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic offer(input logic [4:0] k, input logic [3:0] n, input logic [63:0] b);
    int w;
    @(negedge clk_sys);
    link_msg_valid = 1'b1;
    link_msg = {k, n, b};
    w = 0;
    do begin
      @(posedge clk_sys);
      w++;
    end while (link_msg_ready !== 1'b1 && w < 50);
    if (link_msg_ready !== 1'b1) failures++;
    @(negedge clk_sys);
    link_msg_valid = 1'b0;
    link_msg = ~link_msg;
  endtask
  task automatic t_rx();
    um_u.rx_q.delete();
    offer(5'h03, 4'h0, 64'h0);
    offer(5'h11, 4'h1, 64'hA5);
    offer(5'h1F, 4'h8, 64'h8877_6655_4433_2211);
    repeat (20) @(negedge clk_sys);
    check(um_u.rx_q.size(), 10);
    check(um_u.rx_q[0], {5'h03, 8'h00});
    check(um_u.rx_q[1], {5'h11, 8'hA5});
    for (int i = 0; i < 8; i++) check(um_u.rx_q[i + 2], {5'h1F, 8'(8'h11 * (i + 1))});
  endtask
  task automatic t_off();
    rx_notice_port_enable_attr = 1'b0;
    repeat (2) @(negedge clk_sys);
    um_u.rx_q.delete();
    offer(5'h07, 4'h2, 64'h1234);
    repeat (10) @(negedge clk_sys);
    check(um_u.rx_q.size(), 0);
    rx_notice_port_enable_attr = 1'b1;
  endtask
  task automatic t_tx();
    logic [31:0] d;
    for (int t = 0; t < 8; t++) begin
      d = t == 0 ? 32'h9555_8AAA : t == 1 ? 32'h0000_000A : t == 2 ? 32'h0000_02C5 : 32'h0000_03A3;
      um_u.send(t[2:0], d, t % 2);
      check(um_u.lat, 5);
      if (t < 4) check(tx_msg_q, {t[2:0], d});
      else check(tx_msg_reserved, 1'b1);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    t_rx();
    t_off();
    t_tx();
    report_and_stop();
  end
  // whole run is under 200 cycles; allow ten times that
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule // cmsg_port_test

/* testbench/cmsg_user_model.sv */
// cmsg_user_model.sv: user logic on the far side of the port
// assumes: send is called from bench code between edges
`timescale 1ns/1ns
module cmsg_user_model (
  // clock and receive
  input wire logic       clk_sys,
  input wire logic       msg_rx_strobe,
  input wire logic [4:0] msg_rx_type,
  input wire logic [7:0] msg_rx_data,
  // transmit
  input wire logic       msg_tx_done,
  output logic           msg_tx_req,
  output logic [2:0]     msg_tx_type,
  output logic [31:0]    msg_tx_data
);
  logic [12:0] rx_q[$];
  int          lat;
  initial begin
    msg_tx_req = 1'b0;
    msg_tx_type = 3'h0;
    msg_tx_data = '0;
  end
  always @(posedge clk_sys) begin
    if (msg_rx_strobe === 1'b1) rx_q.push_back({msg_rx_type, msg_rx_data});
  end
  task automatic send(input logic [2:0] t, input logic [31:0] d, input int slow);
    repeat (slow + 1) @(negedge clk_sys);
    msg_tx_req = 1'b1;
    msg_tx_type = t;
    msg_tx_data = d;
    lat = 0;
    do begin
      @(posedge clk_sys);
      lat++;
    end while (msg_tx_done !== 1'b1 && lat < 20);
    @(negedge clk_sys);
    msg_tx_req = 1'b0;
    msg_tx_type = ~t;
    msg_tx_data = ~d;
  endtask
endmodule // cmsg_user_model

/* verilog/cmsg_defines.svh */
// cmsg_defines.svh: offsets, field positions and counts for the message port
// assumes: included by bare name from the design files
`ifndef CMSG_DEFINES_SVH
`define CMSG_DEFINES_SVH

`define CMSG_TX_LTR        3'h0
`define CMSG_TX_OBFF       3'h1
`define CMSG_TX_SSPL       3'h2
`define CMSG_TX_PME        3'h3
`define CMSG_LTR_SNP_REQ   31
`define CMSG_LTR_SNP_SC_HI 28
`define CMSG_LTR_SNP_SC_LO 26
`define CMSG_LTR_SNP_V_HI  25
`define CMSG_LTR_SNP_V_LO  16
`define CMSG_LTR_NS_REQ    15
`define CMSG_LTR_NS_SC_HI  12
`define CMSG_LTR_NS_SC_LO  10
`define CMSG_LTR_NS_V_HI   9
`define CMSG_OBFF_HI       3
`define CMSG_SSPL_HI       9
`define CMSG_PME_PF_HI     1
`define CMSG_PME_VF_HI     9
`define CMSG_PME_VF_LO     4
`define CMSG_RX_MAX_BYTES  4'h8
`define CMSG_TX_LAT        3'h3

`endif

/* verilog/cmsg_pkg.sv */
// cmsg_pkg.sv: types of the side-band message port
// assumes: nothing
package cmsg_pkg;
  typedef struct packed {
    logic       valid;
    logic [4:0] kind;
    logic [7:0] data;
  } cmsg_rx_beat_t;

  typedef struct packed {
    logic [2:0]  kind;
    logic [31:0] data;
  } cmsg_tx_req_t;

  // link-side message decoded into a header plus up to eight parameter bytes
  typedef struct packed {
    logic [4:0]  kind;
    logic [3:0]  nbytes;
    logic [63:0] bytes;
  } cmsg_rx_msg_t;

  typedef struct packed {
    logic [2:0]  kind;
    logic [31:0] fields;
  } cmsg_tx_out_t;

  typedef enum logic [2:0] {
    CMSG_RX_IDLE = 3'b001,
    CMSG_RX_SEND = 3'b010,
    CMSG_RX_GAP  = 3'b100
  } cmsg_rx_st_t;
endpackage

/* verilog/cmsg_port.sv */
// cmsg_port.sv: side-band message port between the core and user logic
// assumes: one clock; decoded link messages arrive with link_msg_valid held until link_msg_ready from core logic
//
// Notes on behaviour
// R1: strobe held one or more cycles per message
// R2: parameter bytes only while strobe high
// R3: at least one idle cycle between messages
// R4: strobe silent unless enable attribute set
// R5: five-bit type valid with strobe
// R6: user holds request until done
// R7: three-bit type codes; upper four reserved
// R8: ltr snoop fields in upper half
// R9: ltr no-snoop fields in lower half
// R10: obff code in low nibble
// R11: slot power scale then value
// R12: pme flags for pf and vf
// R13: done is one clock pulse
// R14: user drops request after done
`timescale 1ns/1ns
`include "cmsg_defines.svh"
module cmsg_port (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // configuration
  input  wire logic                   rx_notice_port_enable_attr,
  // decoded messages from the link side
  input  wire logic                   link_msg_valid,
  input  wire cmsg_pkg::cmsg_rx_msg_t link_msg,
  output      logic                   link_msg_ready,
  // received message interface
  output      logic                   msg_rx_strobe,
  output      logic [4:0]             msg_rx_type,
  output      logic [7:0]             msg_rx_data,
  // transmit message interface
  input  wire logic                   msg_tx_req,
  input  wire logic [2:0]             msg_tx_type,
  input  wire logic [31:0]            msg_tx_data,
  output      logic                   msg_tx_done,
  // packed message towards the transmit path
  output      cmsg_pkg::cmsg_tx_out_t tx_msg_q,
  output      logic                   tx_msg_start,
  output      logic                   tx_msg_reserved
);
  cmsg_pkg::cmsg_rx_st_t st_q, st_d;
  cmsg_pkg::cmsg_rx_msg_t msg_q;
  logic [3:0] idx_q;
  cmsg_pkg::cmsg_rx_beat_t beat_q;
  logic       en_q;
  logic       tx_busy_q;
  logic [2:0] tx_cnt_q;
  logic       done_q;
  logic       tx_hold_q;

  function automatic logic [7:0] pick_byte(input logic [63:0] b, input logic [3:0] i);
    pick_byte = b[{i[2:0], 3'h0} +: 8];
  endfunction

  // enable is a static configuration attribute, sampled so the pin never feeds logic raw
  always_ff @(posedge clk_sys) begin
    if (rst) en_q <= 1'b0;
    else     en_q <= rx_notice_port_enable_attr;
  end

  // R4 gate intake on enable
  wire take_w   = (st_q == cmsg_pkg::CMSG_RX_IDLE) && link_msg_valid && en_q;
  wire [3:0] last_w = (msg_q.nbytes == 4'h0) ? 4'h0 : msg_q.nbytes - 4'h1;
  wire       end_w  = (st_q == cmsg_pkg::CMSG_RX_SEND) && (idx_q == last_w);
  // messages arriving while disabled are dropped rather than stalled
  assign link_msg_ready = (st_q == cmsg_pkg::CMSG_RX_IDLE);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      cmsg_pkg::CMSG_RX_IDLE: if (take_w) st_d = cmsg_pkg::CMSG_RX_SEND;
      // R1 stay for every byte
      cmsg_pkg::CMSG_RX_SEND: if (end_w)  st_d = cmsg_pkg::CMSG_RX_GAP;
      // R3 one idle cycle
      cmsg_pkg::CMSG_RX_GAP:              st_d = cmsg_pkg::CMSG_RX_IDLE;
      default:                            st_d = cmsg_pkg::CMSG_RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q  <= cmsg_pkg::CMSG_RX_IDLE;
      msg_q <= '0;
      idx_q <= 4'h0;
    end else begin
      st_q <= st_d;
      if (take_w) begin
        msg_q <= link_msg;
        if (link_msg.nbytes > `CMSG_RX_MAX_BYTES) msg_q.nbytes <= `CMSG_RX_MAX_BYTES;
        idx_q <= 4'h0;
      end else if (st_q == cmsg_pkg::CMSG_RX_SEND) begin
        idx_q <= idx_q + 4'h1;
      end
    end
  end

  // registered beat; R2 data zero off strobe, R5 type with strobe
  always_ff @(posedge clk_sys) begin
    if (rst) beat_q <= '0;
    else if (st_q == cmsg_pkg::CMSG_RX_SEND)
      beat_q <= '{valid: 1'b1, kind: msg_q.kind,
                  data: (msg_q.nbytes == 4'h0) ? 8'h00 : pick_byte(msg_q.bytes, idx_q)};
    else beat_q <= '0;
  end

  assign msg_rx_strobe = beat_q.valid;
  assign msg_rx_type   = beat_q.kind;
  assign msg_rx_data   = beat_q.data;

  // transmit: accept a held request, wait a fixed latency, pulse done
  // R14 done cycle blocks a take: busy has already dropped there
  wire tx_take_w = msg_tx_req && !tx_busy_q && !tx_hold_q && !done_q;
  cmsg_pkg::cmsg_tx_req_t tx_req_w;
  assign tx_req_w = '{kind: msg_tx_type, data: msg_tx_data};

  cmsg_tx_pack u_pack (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .load       (tx_take_w),
    .req        (tx_req_w),
    .out_q      (tx_msg_q),
    .bad_type_q (tx_msg_reserved)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q  <= 3'h0;
      done_q    <= 1'b0;
      tx_hold_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (tx_take_w) begin
        tx_busy_q <= 1'b1;
        tx_cnt_q  <= `CMSG_TX_LAT;
      end else if (tx_busy_q) begin
        tx_cnt_q <= tx_cnt_q - 3'h1;
        // R13 single done pulse
        if (tx_cnt_q == 3'h1) begin
          tx_busy_q <= 1'b0;
          done_q    <= 1'b1;
        end
      end
      // R14 hold off until the request drops, so one request yields one message
      if (done_q) tx_hold_q <= 1'b1;
      else if (!msg_tx_req) tx_hold_q <= 1'b0;
    end
  end

  assign msg_tx_done  = done_q;
  assign tx_msg_start = tx_take_w;
endmodule // cmsg_port

/* verilog/cmsg_tx_pack.sv */
// cmsg_tx_pack.sv: picks the fields that a transmit type uses out of the data word
// assumes: data held steady by the requester while the request is up
`timescale 1ns/1ns
`include "cmsg_defines.svh"
module cmsg_tx_pack (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // request
  input  wire logic                  load,
  input  wire cmsg_pkg::cmsg_tx_req_t req,
  // packed fields and a reserved-type flag
  output      cmsg_pkg::cmsg_tx_out_t out_q,
  output      logic                  bad_type_q
);
  logic [31:0] fields_w;
  logic        bad_w;

  // R8 R9 ltr fields kept
  wire [31:0] ltr_w = {req.data[`CMSG_LTR_SNP_REQ], 2'h0,
                       req.data[`CMSG_LTR_SNP_SC_HI:`CMSG_LTR_SNP_V_LO],
                       req.data[`CMSG_LTR_NS_REQ], 2'h0,
                       req.data[`CMSG_LTR_NS_SC_HI:0]};
  // R10 obff code
  wire [31:0] obff_w = {28'h0000000, req.data[`CMSG_OBFF_HI:0]};
  // R11 scale over value
  wire [31:0] sspl_w = {22'h000000, req.data[`CMSG_SSPL_HI:0]};
  // R12 pf and vf flags
  wire [31:0] pme_w = {22'h000000, req.data[`CMSG_PME_VF_HI:`CMSG_PME_VF_LO], 2'h0,
                       req.data[`CMSG_PME_PF_HI:0]};

  // R7 type decode
  assign bad_w    = req.kind[2];
  assign fields_w = (req.kind == `CMSG_TX_LTR)  ? ltr_w  :
                    (req.kind == `CMSG_TX_OBFF) ? obff_w :
                    (req.kind == `CMSG_TX_SSPL) ? sspl_w :
                    (req.kind == `CMSG_TX_PME)  ? pme_w  : 32'h00000000;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_q      <= '0;
      bad_type_q <= 1'b0;
    end else if (load) begin
      out_q      <= '{kind: req.kind, fields: fields_w};
      bad_type_q <= bad_w;
    end
  end
endmodule // cmsg_tx_pack
